// >>> gas_sensor_mode_power_control_test.sv
// self-checking bench for the gas sensor mode and power controller
// assumes gsp_host drives the link and shortened timing parameters
module gas_sensor_mode_power_control_test import gsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] KEY = 32'h1234_ABCD; // arbitrary restart key
  logic        clock, srst, hard_reset_n, wake_request_n, result_read;
  logic        link_clk, link_srst, link_start, link_byte_valid, link_stop;
  logic [7:0]  link_byte;
  logic [15:0] eco2_raw, etvoc_raw, eco2_ppm, etvoc_ppb;
  logic [31:0] comp_in_use;
  logic        irq_out_n, data_ready, readings_usable, app_mode, app_valid;
  logic        link_ready, busy, asleep;
  logic [2:0]  mode_now;
  int          bad_count = 0;
  int          n_tests = 0;
  gsp_ctrl #(.START_CYCLES(50), .WAKE_CYCLES(20), .TICK_CYCLES(10), .BURN_TICKS(100),
    .RESTART_KEY(KEY)) dut (.*);
  gsp_host host (.*);
  // 100 MHz system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wt(ref logic sig, input logic val, input int lim);
    for (int k = 0; sig !== val; k++) begin
      if (k > lim) begin
        bad_count++;
        finish_test();
      end
      step(1);
    end
  endtask
  task automatic t_boot();
    chk({irq_out_n, data_ready, app_mode, mode_now}, 6'h20);
    chk(eco2_ppm, ECO2_MIN);
    chk(readings_usable, 1'b0);
    wt(link_ready, 1'b1, 80);
    chk(app_valid, 1'b1);
    host.send(ADR_LAUNCH, 32'h0, 0);
    step(10);
    chk({app_mode, link_ready}, 2'h2);
    wt(link_ready, 1'b1, 70);
  endtask
  // each step goes to a faster rate, to idle or to refused mode 7, so no idle wait is owed
  task automatic t_modes();
    logic [2:0] seq [6] = '{3'h3, 3'h2, 3'h1, 3'h4, 3'h0, 3'h7};
    foreach (seq[i]) begin
      host.send(ADR_MEASURE, {25'h0, seq[i], 4'h0}, 1);
      step(10);
      chk(mode_now, (seq[i] > MODE_MAX) ? 3'h0 : seq[i]);
    end
    step(3000);
    chk(data_ready, 1'b0);
  endtask
  // threshold mode on: first result stays in the low range, second jumps to high
  // baseline is never written, so the run-in wait owed before one is kept
  task automatic t_measure();
    host.send(ADR_MEASURE, 32'h1C, 1);
    step(10);
    chk(mode_now, 3'h1);
    wt(data_ready, 1'b1, 10200);
    chk({irq_out_n, eco2_ppm, etvoc_ppb}, {1'b1, ECO2_MIN, TVOC_MAX});
    eco2_raw = 16'hFFFF;
    etvoc_raw = 16'h0000;
    result_read = 1'b1;
    step(1);
    result_read = 1'b0;
    step(1);
    chk({irq_out_n, data_ready, busy}, 3'h4);
    host.send(ADR_AMBIENT, 32'h1111_2222, 4);
    step(10);
    chk(comp_in_use, 32'h0);
    step(9700);
    chk(data_ready, 1'b0);
    wt(data_ready, 1'b1, 600);
    chk({irq_out_n, eco2_ppm, etvoc_ppb}, {1'b0, ECO2_MAX, TVOC_MIN});
    chk({comp_in_use, readings_usable}, {32'h1111_2222, 1'b1});
  endtask
  task automatic t_sleep();
    wake_request_n = 1'b1;
    wt(asleep, 1'b1, 300);
    host.send(ADR_MEASURE, 32'h0, 1);
    step(10);
    chk(mode_now, 3'h1);
    wake_request_n = 1'b0;
    wt(link_ready, 1'b1, 40);
    host.send(ADR_RESTART, ~KEY, 4);
    step(10);
    chk(app_mode, 1'b1);
    hard_reset_n = 1'b0;
    step(8);
    chk({app_mode, mode_now, link_ready}, 5'h0);
    hard_reset_n = 1'b1;
    wt(link_ready, 1'b1, 70);
    host.send(ADR_LAUNCH, 32'h0, 0);
    step(10);
    wt(link_ready, 1'b1, 70);
    host.send(ADR_RESTART, KEY, 4);
    step(10);
    chk(app_mode, 1'b0);
    wt(link_ready, 1'b1, 70);
    host.send(ADR_FW_ERASE, 64'h0, 0);
    step(10);
    chk(app_valid, 1'b0);
    host.send(ADR_FW_CHUNK, 64'h0123_4567_89AB_CDEF, 8);
    host.send(ADR_FW_CHECK, 64'h0, 0);
    step(10);
    chk(app_valid, 1'b1);
  endtask
  // main sequence; wake held low so the link stays usable
  initial begin
    srst = 1'b1;
    hard_reset_n = 1'b1;
    wake_request_n = 1'b0;
    result_read = 1'b0;
    eco2_raw = 16'h0010;
    etvoc_raw = 16'hFFFF;
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    t_boot();
    t_modes();
    t_measure();
    t_sleep();
    finish_test();
  end
endmodule

// >>> gsp_ctrl.sv
// mode, power state and measurement scheduler of the gas sensor
// assumes link frames arrive on link_clk and results from an analog front end
// Functional notes
// - address-only write of launch register moves boot into application mode
// - writing 1 to the mode field of measure_config selects one_second_mode, results every second
// - restart write with correct four-byte key returns device to boot mode
// - busy during link transaction, measurement or algorithm, not for timer alone
// - modes: 0 idle, 1 1s, 2 10s, 3 60s, 4 250ms raw
// - with no work go sleep if wake_request_n high, else idle
// - in idle a transaction or timer expiry makes device busy
// - sleep ignores link traffic; wake low gives idle, timer gives busy
// - hard_reset_n resets from any state; restart honoured only while awake
// - modes 1 to 3 compute both gas values for every sample
// - intervals come from internal clock within 2 percent
// - readings flagged usable after 60 minutes in modes 1 to 3
// - carbon dioxide result clamped to 400 through 32768
// - organic compound result clamped to 0 through 29206
// - next result may use old compensation, later ones use new
// - each completed cycle sets data ready and, if enabled, irq_out_n
// - in modes 1 to 3 threshold mode interrupts only when result changes range
// - link accepted within 50 us after wake_request_n falls
// - link accepted within 2 ms after hard or soft reset
// - all data bytes of one transfer go to the selected register
module gsp_ctrl import gsp_pkg::*; #(
  parameter int unsigned START_CYCLES = START_CYC,
  parameter int unsigned WAKE_CYCLES  = WAKE_CYC,
  parameter int unsigned TICK_CYCLES  = TICK_CYC,
  parameter int unsigned BURN_TICKS   = BURN_MS,
  parameter logic [31:0] RESTART_KEY  = 32'h5A5A_C3C3, // arbitrary value
  parameter logic        APP_PRESENT  = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        hard_reset_n,
  input  wire logic        wake_request_n,
  input  wire logic        link_clk,
  input  wire logic        link_srst,
  input  wire logic        link_start,
  input  wire logic        link_byte_valid,
  input  wire logic [7:0]  link_byte,
  input  wire logic        link_stop,
  input  wire logic [15:0] eco2_raw,
  input  wire logic [15:0] etvoc_raw,
  input  wire logic        result_read,
  output logic             irq_out_n,
  output logic             data_ready,
  output logic [15:0]      eco2_ppm,
  output logic [15:0]      etvoc_ppb,
  output logic [31:0]      comp_in_use,
  output logic             readings_usable,
  output logic             app_mode,
  output logic             app_valid,
  output logic             link_ready,
  output logic             busy,
  output logic             asleep,
  output logic [2:0]       mode_now
);
  // limit a value to a window, used for both gas results
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // measurement interval of a mode in milliseconds
  function automatic logic [15:0] interval_ms(input logic [2:0] m);
    case (m)
      3'h1:    interval_ms = IVL_MODE1_MS;
      3'h2:    interval_ms = IVL_MODE2_MS;
      3'h3:    interval_ms = IVL_MODE3_MS;
      default: interval_ms = IVL_MODE4_MS;
    endcase
  endfunction

  logic        x_act, x_tgl;
  logic [7:0]  x_addr;
  logic [3:0]  x_len;
  logic [31:0] x_data;
  logic        rst_n_s, wake_n_s, act_s, tgl_s;

  gsp_link_rx u_rx (
    .link_clk        (link_clk),
    .link_srst       (link_srst),
    .link_start      (link_start),
    .link_byte_valid (link_byte_valid),
    .link_byte       (link_byte),
    .link_stop       (link_stop),
    .xfer_active     (x_act),
    .xfer_toggle     (x_tgl),
    .xfer_addr       (x_addr),
    .xfer_len        (x_len),
    .xfer_data       (x_data)
  );

  // pins and link levels enter through three stages each
  gsp_sync3 #(.RST_VAL(1'b1)) u_s_rst  (.clock(clock), .srst(srst),
                                        .din(hard_reset_n), .dout(rst_n_s));
  gsp_sync3 #(.RST_VAL(1'b1)) u_s_wake (.clock(clock), .srst(srst),
                                        .din(wake_request_n), .dout(wake_n_s));
  gsp_sync3 #(.RST_VAL(1'b0)) u_s_act  (.clock(clock), .srst(srst),
                                        .din(x_act), .dout(act_s));
  gsp_sync3 #(.RST_VAL(1'b0)) u_s_tgl  (.clock(clock), .srst(srst),
                                        .din(x_tgl), .dout(tgl_s));

  gsp_pwr_e    pwr_ff, nxt_pwr;
  gsp_fn_e     fn_ff, nxt_fn;
  gsp_work_e   work_ff, nxt_work;
  logic [2:0]  mode_ff, nxt_mode;
  logic        int_en_ff, nxt_int_en, thr_en_ff, nxt_thr_en;
  logic [15:0] thr_lo_ff, nxt_thr_lo, thr_hi_ff, nxt_thr_hi;
  logic [31:0] comp_new_ff, nxt_comp_new, comp_use_ff, nxt_comp_use;
  logic        comp_pend_ff, nxt_comp_pend;
  logic        erased_ff, nxt_erased, valid_ff, nxt_valid;
  logic [15:0] chunks_ff, nxt_chunks;
  logic [31:0] rdy_cnt_ff, nxt_rdy_cnt;
  logic        rdy_ff, nxt_rdy;
  logic [31:0] tick_ff, nxt_tick;
  logic [15:0] ms_ff, nxt_ms;
  logic [31:0] burn_ff, nxt_burn;
  logic        usable_ff, nxt_usable;
  logic [7:0]  wcnt_ff, nxt_wcnt;
  logic [15:0] eco2_ff, nxt_eco2, tvoc_ff, nxt_tvoc;
  logic [1:0]  rng_ff, nxt_rng;
  logic        drdy_ff, nxt_drdy, irq_n_ff, nxt_irq_n;
  logic        tgl_seen_ff, wake_n_d_ff;

  logic        reset_hit, ev, ev_ok, expiry, tick_end, fired, launch_go, restart_go;
  logic [7:0]  d0;
  logic [15:0] new_eco2;
  logic [1:0]  new_rng;

  always_comb begin
    reset_hit = srst || !rst_n_s;
    ev        = (tgl_s != tgl_seen_ff);
    // link traffic is dropped while asleep or not yet ready
    ev_ok     = ev && (pwr_ff != PS_SLEEP) && rdy_ff;
    d0        = x_data[7:0];
    tick_end  = (tick_ff == TICK_CYCLES - 1);
    // timer stands while mode 0 or in boot
    expiry    = (fn_ff == FS_APP) && (mode_ff != 3'h0) && tick_end &&
                (ms_ff >= interval_ms(mode_ff) - 16'h0001);
    new_eco2  = clamp16(eco2_raw, ECO2_MIN, ECO2_MAX);
    new_rng   = (new_eco2 < thr_lo_ff) ? 2'h0 : ((new_eco2 <= thr_hi_ff) ? 2'h1 : 2'h2);
    fired     = !thr_en_ff || (new_rng != rng_ff);
    launch_go = ev_ok && (x_addr == ADR_LAUNCH) && (x_len == 4'h0) &&
                (fn_ff == FS_BOOT) && valid_ff;
    restart_go = ev_ok && (x_addr == ADR_RESTART) && (x_len == LEN_KEY) &&
                 (x_data == RESTART_KEY);
  end

  // command decode, firmware sequence and configuration
  always_comb begin
    nxt_fn        = fn_ff;
    nxt_mode      = mode_ff;
    nxt_int_en    = int_en_ff;
    nxt_thr_en    = thr_en_ff;
    nxt_thr_lo    = thr_lo_ff;
    nxt_thr_hi    = thr_hi_ff;
    nxt_comp_new  = comp_new_ff;
    nxt_comp_pend = comp_pend_ff;
    nxt_erased    = erased_ff;
    nxt_valid     = valid_ff;
    nxt_chunks    = chunks_ff;
    if (work_ff == WK_ALG && wcnt_ff == 8'h01) nxt_comp_pend = 1'b0; // used up by this result
    if (launch_go) begin
      nxt_fn = FS_APP;
    end else if (restart_go) begin
      nxt_fn   = FS_BOOT;
      nxt_mode = MODE_RST;
    end else if (ev_ok && fn_ff == FS_BOOT) begin
      // firmware replacement steps only exist in boot mode
      if (x_addr == ADR_FW_ERASE) begin
        nxt_erased = 1'b1;
        nxt_valid  = 1'b0;
        nxt_chunks = 16'h0000;
      end else if (x_addr == ADR_FW_CHUNK && erased_ff && x_len == LEN_CHUNK) begin
        nxt_chunks = chunks_ff + 16'h0001;
      end else if (x_addr == ADR_FW_CHECK) begin
        nxt_valid  = erased_ff && (chunks_ff != 16'h0000);
        nxt_erased = 1'b0;
      end
    end else if (ev_ok && fn_ff == FS_APP) begin
      if (x_addr == ADR_MEASURE && x_len != 4'h0) begin
        // unknown modes are refused and the old mode stays
        if (d0[MC_MODE_LSB +: 3] <= MODE_MAX) nxt_mode = d0[MC_MODE_LSB +: 3];
        nxt_int_en = d0[MC_INT_BIT];
        nxt_thr_en = d0[MC_THR_BIT];
      end else if (x_addr == ADR_AMBIENT && x_len == LEN_KEY) begin
        nxt_comp_new  = x_data;
        nxt_comp_pend = 1'b1;
      end else if (x_addr == ADR_THRESH && x_len == LEN_KEY) begin
        nxt_thr_lo = x_data[31:16];
        nxt_thr_hi = x_data[15:0];
      end
    end
  end

  // power state, work sequence, timers and results
  always_comb begin
    nxt_pwr      = pwr_ff;
    nxt_work     = work_ff;
    nxt_wcnt     = wcnt_ff;
    nxt_rdy_cnt  = rdy_cnt_ff;
    nxt_rdy      = rdy_ff;
    nxt_tick     = tick_end ? 32'h0000_0000 : tick_ff + 32'h0000_0001;
    nxt_ms       = ms_ff;
    nxt_burn     = burn_ff;
    nxt_usable   = usable_ff;
    nxt_eco2     = eco2_ff;
    nxt_tvoc     = tvoc_ff;
    nxt_rng      = rng_ff;
    nxt_drdy     = drdy_ff;
    nxt_irq_n    = irq_n_ff;
    nxt_comp_use = comp_use_ff;
    // host read clears the flag; a completion below wins over it
    if (result_read) begin
      nxt_drdy  = 1'b0;
      nxt_irq_n = 1'b1;
    end
    if (fn_ff == FS_APP && mode_ff != 3'h0) begin
      if (tick_end) nxt_ms = expiry ? 16'h0000 : ms_ff + 16'h0001;
    end else begin
      nxt_ms = 16'h0000;
    end
    if (fn_ff == FS_APP && mode_ff != 3'h0 && mode_ff != 3'h4 && tick_end &&
        !usable_ff) begin
      nxt_burn = burn_ff + 32'h0000_0001;
      if (burn_ff == BURN_TICKS - 1) nxt_usable = 1'b1;
    end
    // measurement then one algorithm step, none in mode 4
    case (work_ff)
      WK_NONE: begin
        if (expiry) begin
          nxt_work = WK_MEAS;
          nxt_wcnt = MEAS_CYC;
        end
      end
      WK_MEAS: begin
        if (wcnt_ff == 8'h01) begin
          nxt_work = (mode_ff == 3'h4) ? WK_NONE : WK_ALG;
          nxt_wcnt = ALG_CYC;
          if (mode_ff == 3'h4) begin
            nxt_drdy = 1'b1;
            if (int_en_ff) nxt_irq_n = 1'b0;
          end
        end else begin
          nxt_wcnt = wcnt_ff - 8'h01;
        end
      end
      WK_ALG: begin
        if (wcnt_ff == 8'h01) begin
          nxt_work = WK_NONE;
          nxt_eco2 = new_eco2;
          nxt_tvoc = clamp16(etvoc_raw, TVOC_MIN, TVOC_MAX);
          nxt_rng  = new_rng;
          nxt_drdy = 1'b1;
          if (int_en_ff && fired) nxt_irq_n = 1'b0;
          // a compensation write lands after the result in flight
          if (comp_pend_ff) nxt_comp_use = comp_new_ff;
        end else begin
          nxt_wcnt = wcnt_ff - 8'h01;
        end
      end
      default: nxt_work = WK_NONE;
    endcase
    // readiness counter after wake, launch or restart
    if (rdy_cnt_ff != 32'h0000_0000) begin
      nxt_rdy_cnt = rdy_cnt_ff - 32'h0000_0001;
      if (rdy_cnt_ff == 32'h0000_0001) nxt_rdy = 1'b1;
    end
    if (wake_n_d_ff && !wake_n_s && !rdy_ff && rdy_cnt_ff == 32'h0) nxt_rdy_cnt = WAKE_CYCLES;
    if (launch_go || restart_go) begin
      nxt_rdy     = 1'b0;
      nxt_rdy_cnt = START_CYCLES;
      if (restart_go) begin
        nxt_work = WK_NONE;
        nxt_drdy = 1'b0;
        nxt_irq_n = 1'b1;
      end
    end
    // power state follows pending work and the wake pin
    case (pwr_ff)
      PS_SLEEP: begin
        if (expiry) begin
          nxt_pwr = PS_BUSY;
        end else if (!wake_n_s) begin
          nxt_pwr = PS_IDLE;
        end
        if (!expiry && !wake_n_s) nxt_rdy_cnt = WAKE_CYCLES;
      end
      PS_IDLE, PS_BUSY: begin
        if (act_s || ev_ok || expiry || nxt_work != WK_NONE) begin
          nxt_pwr = PS_BUSY;
        end else if (wake_n_s) begin
          nxt_pwr = PS_SLEEP;
          nxt_rdy = 1'b0;
          nxt_rdy_cnt = 32'h0000_0000;
        end else begin
          nxt_pwr = PS_IDLE;
        end
      end
      default: nxt_pwr = PS_BUSY;
    endcase
  end

  always_ff @(posedge clock) begin
    tgl_seen_ff <= srst ? 1'b0 : tgl_s;
    wake_n_d_ff <= srst ? 1'b1 : wake_n_s;
    if (srst) begin
      valid_ff  <= APP_PRESENT; // image survives pin reset
      burn_ff   <= 32'h0000_0000;
      usable_ff <= 1'b0;
    end else begin
      valid_ff  <= nxt_valid;
      burn_ff   <= nxt_burn;
      usable_ff <= nxt_usable;
    end
    if (reset_hit) begin
      pwr_ff       <= PS_BUSY;
      fn_ff        <= FS_BOOT;
      work_ff      <= WK_NONE;
      mode_ff      <= MODE_RST;
      int_en_ff    <= 1'b0;
      thr_en_ff    <= 1'b0;
      thr_lo_ff    <= THR_LO_RST;
      thr_hi_ff    <= THR_HI_RST;
      comp_new_ff  <= 32'h0000_0000;
      comp_use_ff  <= 32'h0000_0000;
      comp_pend_ff <= 1'b0;
      erased_ff    <= 1'b0;
      chunks_ff    <= 16'h0000;
      rdy_cnt_ff   <= START_CYCLES;
      rdy_ff       <= 1'b0;
      tick_ff      <= 32'h0000_0000;
      ms_ff        <= 16'h0000;
      wcnt_ff      <= 8'h00;
      eco2_ff      <= ECO2_MIN;
      tvoc_ff      <= TVOC_MIN;
      rng_ff       <= 2'h0;
      drdy_ff      <= 1'b0;
      irq_n_ff     <= 1'b1;
    end else begin
      pwr_ff       <= nxt_pwr;
      fn_ff        <= nxt_fn;
      work_ff      <= nxt_work;
      mode_ff      <= nxt_mode;
      int_en_ff    <= nxt_int_en;
      thr_en_ff    <= nxt_thr_en;
      thr_lo_ff    <= nxt_thr_lo;
      thr_hi_ff    <= nxt_thr_hi;
      comp_new_ff  <= nxt_comp_new;
      comp_use_ff  <= nxt_comp_use;
      comp_pend_ff <= nxt_comp_pend;
      erased_ff    <= nxt_erased;
      chunks_ff    <= nxt_chunks;
      rdy_cnt_ff   <= nxt_rdy_cnt;
      rdy_ff       <= nxt_rdy;
      tick_ff      <= nxt_tick;
      ms_ff        <= nxt_ms;
      wcnt_ff      <= nxt_wcnt;
      eco2_ff      <= nxt_eco2;
      tvoc_ff      <= nxt_tvoc;
      rng_ff       <= nxt_rng;
      drdy_ff      <= nxt_drdy;
      irq_n_ff     <= nxt_irq_n;
    end
  end

  // outputs straight from state
  assign irq_out_n       = irq_n_ff;
  assign data_ready      = drdy_ff;
  assign eco2_ppm        = eco2_ff;
  assign etvoc_ppb       = tvoc_ff;
  assign comp_in_use     = comp_use_ff;
  assign readings_usable = usable_ff;
  assign app_mode        = (fn_ff == FS_APP);
  assign app_valid       = valid_ff;
  assign link_ready      = rdy_ff;
  assign busy            = (pwr_ff == PS_BUSY);
  assign asleep          = (pwr_ff == PS_SLEEP);
  assign mode_now        = mode_ff;
endmodule

// >>> gsp_ctrl_sva.sv
// output checker for the gas sensor controller, bound to gsp_ctrl
// sees only top ports; everything lives in the system clock domain
module gsp_ctrl_sva import gsp_pkg::*; (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        hard_reset_n,
  input wire logic        wake_request_n,
  input wire logic        irq_out_n,
  input wire logic        data_ready,
  input wire logic [15:0] eco2_ppm,
  input wire logic [15:0] etvoc_ppb,
  input wire logic        app_mode,
  input wire logic        link_ready,
  input wire logic        busy,
  input wire logic        asleep,
  input wire logic [2:0]  mode_now
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // range and state checks
  AST_MODE_MAX: assert property (mode_now <= MODE_MAX)
    else $error("mode beyond range");
  AST_ECO2_RANGE: assert property (eco2_ppm >= ECO2_MIN && eco2_ppm <= ECO2_MAX)
    else $error("eco2 out of range");
  AST_TVOC_RANGE: assert property (etvoc_ppb <= TVOC_MAX)
    else $error("etvoc out of range");
  AST_IRQ_FLAG: assert property (!irq_out_n |-> data_ready)
    else $error("irq without data ready");
  AST_DONE_WORK: assert property ($rose(data_ready) |-> $past(busy) && mode_now != 3'h0)
    else $error("data ready without work");
  AST_SLEEP_DEAF: assert property (asleep |-> !link_ready)
    else $error("link ready while asleep");
  // sync delay of the pins allows a few cycles before acting
  AST_WAKE_LOW: assert property ((!wake_request_n)[*8] |-> !asleep)
    else $error("asleep with wake held low");
  AST_HARD_RST: assert property ((!hard_reset_n)[*8] |-> irq_out_n && !data_ready && !app_mode)
    else $error("hard reset not honoured");
  AST_LAUNCH_WAIT: assert property ($rose(app_mode) |-> ##[0:2] !link_ready)
    else $error("ready too early after launch");
endmodule
bind gsp_ctrl gsp_ctrl_sva chk (
  .clock(clock), .srst(srst), .hard_reset_n(hard_reset_n), .wake_request_n(wake_request_n),
  .irq_out_n(irq_out_n), .data_ready(data_ready), .eco2_ppm(eco2_ppm), .etvoc_ppb(etvoc_ppb),
  .app_mode(app_mode), .link_ready(link_ready), .busy(busy), .asleep(asleep),
  .mode_now(mode_now)
);

// >>> gsp_host.sv
// link master model: frames of start, address, data bytes and stop
// link clock stands still between frames; a released byte line is inverted
module gsp_host (
  output logic       link_clk,
  output logic       link_srst,
  output logic       link_start,
  output logic       link_byte_valid,
  output logic [7:0] link_byte,
  output logic       link_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  // one beat: drive first, then one full 125 ns period
  task automatic beat(input logic s, input logic v, input logic p, input logic [7:0] b);
    {link_start, link_byte_valid, link_stop, link_byte} = {s, v, p, b};
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
  endtask
  // address then data msb first; one register for all bytes
  task automatic send(input logic [7:0] adr, input logic [63:0] dat, input int n);
    beat(1'b1, 1'b0, 1'b0, ~adr);
    beat(1'b0, 1'b1, 1'b0, adr);
    for (int i = n - 1; i >= 0; i--) beat(1'b0, 1'b1, 1'b0, dat[8*i+:8]);
    beat(1'b0, 1'b0, 1'b1, ~link_byte);
    link_byte = ~link_byte;
  endtask
  // link reset needs edges while held
  initial begin
    link_clk = 1'b0;
    link_srst = 1'b1;
    beat(1'b0, 1'b0, 1'b0, 8'h00);
    beat(1'b0, 1'b0, 1'b0, 8'hFF);
    link_srst = 1'b0;
  end
endmodule

// >>> gsp_link_rx.sv
// link-side byte collector: first byte selects a register, the rest are data
// runs on link_clk; start and stop bound the collecting state, the held copies stay until a later stop
module gsp_link_rx import gsp_pkg::*; (
  input  wire logic        link_clk,
  input  wire logic        link_srst,
  input  wire logic        link_start,
  input  wire logic        link_byte_valid,
  input  wire logic [7:0]  link_byte,
  input  wire logic        link_stop,
  output logic             xfer_active,
  output logic             xfer_toggle,
  output logic [7:0]       xfer_addr,
  output logic [3:0]       xfer_len,
  output logic [31:0]      xfer_data
);
  logic        act_ff, first_ff, tgl_ff;
  logic [7:0]  adr_ff, adr_q_ff;
  logic [3:0]  len_ff, len_q_ff;
  logic [31:0] dat_ff, dat_q_ff;
  logic        nxt_act, nxt_first, nxt_tgl;
  logic [7:0]  nxt_adr, nxt_adr_q;
  logic [3:0]  nxt_len, nxt_len_q;
  logic [31:0] nxt_dat, nxt_dat_q;

  // no address increment: every data byte belongs to the selected register
  always_comb begin
    nxt_act   = act_ff;
    nxt_first = first_ff;
    nxt_tgl   = tgl_ff;
    nxt_adr   = adr_ff;
    nxt_len   = len_ff;
    nxt_dat   = dat_ff;
    nxt_adr_q = adr_q_ff;
    nxt_len_q = len_q_ff;
    nxt_dat_q = dat_q_ff;
    if (link_start) begin
      nxt_act   = 1'b1;
      nxt_first = 1'b1;
      nxt_len   = 4'h0;
      nxt_dat   = 32'h0000_0000;
    end else if (act_ff && link_byte_valid) begin
      if (first_ff) begin
        nxt_adr   = link_byte;
        nxt_first = 1'b0;
      end else begin
        nxt_dat = {dat_ff[23:0], link_byte};
        if (len_ff != 4'hF) nxt_len = len_ff + 4'h1; // saturate on long frames
      end
    end else if (act_ff && link_stop) begin
      nxt_act = 1'b0;
      // frames with no address byte carry nothing
      if (!first_ff) begin
        nxt_adr_q = adr_ff;
        nxt_len_q = len_ff;
        nxt_dat_q = dat_ff;
        nxt_tgl   = ~tgl_ff;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      act_ff   <= 1'b0;
      first_ff <= 1'b1;
      tgl_ff   <= 1'b0;
      adr_ff   <= 8'h00;
      len_ff   <= 4'h0;
      dat_ff   <= 32'h0000_0000;
      adr_q_ff <= 8'h00;
      len_q_ff <= 4'h0;
      dat_q_ff <= 32'h0000_0000;
    end else begin
      act_ff   <= nxt_act;
      first_ff <= nxt_first;
      tgl_ff   <= nxt_tgl;
      adr_ff   <= nxt_adr;
      len_ff   <= nxt_len;
      dat_ff   <= nxt_dat;
      adr_q_ff <= nxt_adr_q;
      len_q_ff <= nxt_len_q;
      dat_q_ff <= nxt_dat_q;
    end
  end

  assign xfer_active = act_ff;
  assign xfer_toggle = tgl_ff;
  assign xfer_addr   = adr_q_ff;
  assign xfer_len    = len_q_ff;
  assign xfer_data   = dat_q_ff;
endmodule

// >>> gsp_pkg.sv
// constants shared by the gas sensor power and mode controller
// assumes a 100 MHz system clock and a byte-level link front end
package gsp_pkg;
  // timing base
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned START_MAX_MS = 2;
  localparam int unsigned START_CYC    = CLK_HZ / 1000 * START_MAX_MS;
  localparam int unsigned WAKE_MAX_US  = 50;
  localparam int unsigned WAKE_CYC     = CLK_HZ / 1_000_000 * WAKE_MAX_US;
  localparam int unsigned BURN_MIN     = 60;
  localparam int unsigned BURN_MS      = BURN_MIN * 60_000;
  // measurement intervals in milliseconds
  localparam logic [15:0] IVL_MODE1_MS = 16'h03E8;
  localparam logic [15:0] IVL_MODE2_MS = 16'h2710;
  localparam logic [15:0] IVL_MODE3_MS = 16'hEA60;
  localparam logic [15:0] IVL_MODE4_MS = 16'h00FA;
  // sensor drive and algorithm step lengths in cycles
  localparam logic [7:0]  MEAS_CYC     = 8'h40;
  localparam logic [7:0]  ALG_CYC      = 8'h20;
  // register addresses
  localparam logic [7:0]  ADR_STATUS   = 8'h00;
  localparam logic [7:0]  ADR_MEASURE  = 8'h01;
  localparam logic [7:0]  ADR_RESULT   = 8'h02;
  localparam logic [7:0]  ADR_AMBIENT  = 8'h05;
  localparam logic [7:0]  ADR_THRESH   = 8'h10;
  localparam logic [7:0]  ADR_BASELINE = 8'h11;
  localparam logic [7:0]  ADR_FW_ERASE = 8'hF1;
  localparam logic [7:0]  ADR_FW_CHUNK = 8'hF2;
  localparam logic [7:0]  ADR_FW_CHECK = 8'hF3;
  localparam logic [7:0]  ADR_LAUNCH   = 8'hF4;
  localparam logic [7:0]  ADR_RESTART  = 8'hFF;
  // measure_config fields
  localparam int unsigned MC_MODE_LSB  = 4;
  localparam int unsigned MC_INT_BIT   = 3;
  localparam int unsigned MC_THR_BIT   = 2;
  localparam logic [2:0]  MODE_MAX     = 3'h4;
  localparam logic [2:0]  MODE_RST     = 3'h0;
  // lengths of data phases in bytes
  localparam logic [3:0]  LEN_KEY      = 4'h4;
  localparam logic [3:0]  LEN_CHUNK    = 4'h8;
  // result limits
  localparam logic [15:0] ECO2_MIN     = 16'h0190;
  localparam logic [15:0] ECO2_MAX     = 16'h8000;
  localparam logic [15:0] TVOC_MIN     = 16'h0000;
  localparam logic [15:0] TVOC_MAX     = 16'h7216;
  // threshold reset values
  localparam logic [15:0] THR_LO_RST   = 16'h05DC;
  localparam logic [15:0] THR_HI_RST   = 16'h09C4;

  typedef enum logic [1:0] {PS_SLEEP, PS_IDLE, PS_BUSY} gsp_pwr_e;
  typedef enum logic {FS_BOOT, FS_APP} gsp_fn_e;
  typedef enum logic [1:0] {WK_NONE, WK_MEAS, WK_ALG} gsp_work_e;
endpackage

// >>> gsp_sync3.sv
// three-stage synchroniser for one level from another domain
// the output follows once stages two and three agree
module gsp_sync3 import gsp_pkg::*; #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic s1_ff, s2_ff, s3_ff, out_ff;
  logic nxt_out;

  // stage one feeds only stage two
  always_comb begin
    nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      out_ff <= RST_VAL;
    end else begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;
endmodule
